// ==== fwg_top.sv ====
// Flash write guard: enables, key sequence, page security checks.
// Assumes core, debug port and flash macro all run on I_CLK.
//
// Contract
// - external move reads always hit xdata ram
// - modify needs write enable, erase both
// - lock byte complement gives locked pages
// - any lock also locks lock-byte page
// - lock-byte page is 0x1c00 to 0x1dff
// - debug accesses unlocked pages, never locked
// - debug reads lock byte only unlocked
// - device erase clears everything including locks
// - nobody may lock additional pages
// - reserved area never accessed
// - unlocked code faulting on locked resets
// - unlocked code uses lock page if unlocked
// - firmware erase of lock page resets
// - locked code accesses all other pages
// - locked code reads, writes lock page
// - lock byte readable, never unlockable by firmware
// - control bits one and zero
// - both enables erase addressed page
// - two key codes open one operation
// - bad key or early op disables
// - key register reads lock state
// - reserved area 0x1e00 to 0x1fff
// - writes clear bits, erase fills ones
// - hardware times ops, core stalls
`timescale 1ns/1ps
`default_nettype none
module fwg_top (
  input wire logic I_CLK, // Core clock
  input wire logic I_RESET_N, // Device reset, active low
  input wire logic [7:0] I_SFR_ADDR, // Register address
  input wire logic I_SFR_WR, // Register write strobe
  input wire logic [7:0] I_SFR_WDATA, // Register write data
  output logic [7:0] O_SFR_RDATA, // Register read data
  input wire logic I_XW_REQ, // External move write pulse
  input wire logic [15:0] I_XW_ADDR, // External move address
  input wire logic [7:0] I_XW_DATA, // External move data
  output logic O_XDATA_RAM_WR, // Write routed to xdata ram
  output logic O_CORE_STALL, // Core stalled for flash op
  input wire logic I_CR_REQ, // Code move read pulse
  input wire logic [15:0] I_CR_ADDR, // Code move address
  input wire logic [15:0] I_PC_ADDR, // Executing address
  input wire logic I_DBG_REQ, // Debug command pulse
  input wire logic [1:0] I_DBG_CMD, // Debug command
  input wire logic [15:0] I_DBG_ADDR, // Debug address
  input wire logic [7:0] I_DBG_DATA, // Debug write data
  output logic O_DBG_ACK, // Debug command done
  output logic O_DBG_DENY, // Debug command refused
  input wire logic [7:0] I_LOCK_BYTE, // Lock byte from flash
  output logic O_FL_RD, // Flash read start
  output logic O_FL_WR, // Flash byte write start
  output logic O_FL_ERASE, // Flash page erase start
  output logic O_FL_MASS, // Flash full erase start
  output logic [15:0] O_FL_ADDR, // Flash address
  output logic [7:0] O_FL_WDATA, // Flash write data
  input wire logic I_FL_DONE, // Flash op complete
  output logic O_READ_TIME_SEL, // Flash read time bit
  output logic O_FLASH_ERR_RST // Flash error reset pulse
);
  logic we_ff;
  logic ee_ff;
  logic rt_ff;
  logic own_core_ff;
  fwg_pkg::fwg_key_t key_ff;
  fwg_pkg::fwg_key_t nxt_key;
  fwg_pkg::fwg_st_t st_ff;
  fwg_pkg::fwg_st_t nxt_st;
  logic xw_lk, xw_lp, xw_rs;
  logic cr_lk, cr_rs;
  logic pc_lk;
  logic dbg_lk, dbg_rs;
  logic any_lk;
  logic idle, err, key_wr, xw_fl;
  logic wr_fault, er_fault, cr_fault, core_fault;
  logic core_try, core_bad_key, core_blk, core_go;
  logic dbg_take, dbg_mass, dbg_deny, dbg_go;
  logic done;

  fwg_page_check u_xw_chk (
    .i_addr(I_XW_ADDR),
    .i_lock_byte(I_LOCK_BYTE),
    .o_locked(xw_lk),
    .o_lock_page(xw_lp),
    .o_reserved(xw_rs),
    .o_any_locked(any_lk)
  );
  fwg_page_check u_cr_chk (
    .i_addr(I_CR_ADDR),
    .i_lock_byte(I_LOCK_BYTE),
    .o_locked(cr_lk),
    .o_lock_page(),
    .o_reserved(cr_rs),
    .o_any_locked()
  );
  fwg_page_check u_pc_chk (
    .i_addr(I_PC_ADDR),
    .i_lock_byte(I_LOCK_BYTE),
    .o_locked(pc_lk),
    .o_lock_page(),
    .o_reserved(),
    .o_any_locked()
  );
  fwg_page_check u_dbg_chk (
    .i_addr(I_DBG_ADDR),
    .i_lock_byte(I_LOCK_BYTE),
    .o_locked(dbg_lk),
    .o_lock_page(),
    .o_reserved(dbg_rs),
    .o_any_locked()
  );

  // Access decisions for firmware and the debug port.
  always_comb begin
    idle = st_ff == fwg_pkg::ST_IDLE;
    err = st_ff == fwg_pkg::ST_ERR;
    done = (st_ff == fwg_pkg::ST_BUSY) && I_FL_DONE;
    key_wr = I_SFR_WR && (I_SFR_ADDR == fwg_pkg::ADDR_KEY);
    xw_fl = I_XW_REQ && we_ff;
    // Unlocked code may not touch locked pages, lock page included.
    wr_fault = xw_rs || (!pc_lk && xw_lk);
    er_fault = wr_fault || xw_lp;
    // The lock byte itself is always readable by firmware.
    cr_fault = I_CR_REQ && (cr_rs || (!pc_lk && cr_lk &&
               (I_CR_ADDR != fwg_pkg::LOCK_BYTE_ADDR)));
    core_try = idle && xw_fl && (key_ff == fwg_pkg::KEY_OPEN);
    core_bad_key = idle && xw_fl && (key_ff != fwg_pkg::KEY_OPEN);
    core_fault = (core_try && (ee_ff ? er_fault : wr_fault)) ||
                 (idle && cr_fault);
    // Writing the lock byte while locks stand would add locks.
    core_blk = core_try && !core_fault && !ee_ff &&
               (I_XW_ADDR == fwg_pkg::LOCK_BYTE_ADDR) && any_lk;
    core_go = core_try && !core_fault && !core_blk;
    dbg_take = idle && I_DBG_REQ && !xw_fl && !cr_fault;
    dbg_mass = I_DBG_CMD == fwg_pkg::DBG_DEV_ER;
    dbg_deny = dbg_take && !dbg_mass && (dbg_rs || dbg_lk ||
               ((I_DBG_ADDR == fwg_pkg::LOCK_BYTE_ADDR) && any_lk));
    dbg_go = dbg_take && !dbg_deny;
  end

  // Control and read-time registers; a flash error clears them.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      we_ff <= fwg_pkg::RST_BIT;
      ee_ff <= fwg_pkg::RST_BIT;
      rt_ff <= fwg_pkg::RST_BIT;
    end else if (err) begin
      we_ff <= fwg_pkg::RST_BIT;
      ee_ff <= fwg_pkg::RST_BIT;
      rt_ff <= fwg_pkg::RST_BIT;
    end else if (I_SFR_WR) begin
      if (I_SFR_ADDR == fwg_pkg::ADDR_PSC) begin
        we_ff <= I_SFR_WDATA[fwg_pkg::WE_BIT];
        ee_ff <= I_SFR_WDATA[fwg_pkg::EE_BIT];
      end
      if (I_SFR_ADDR == fwg_pkg::ADDR_SCL) begin
        rt_ff <= I_SFR_WDATA[fwg_pkg::RT_BIT];
      end
    end
  end

  // Key sequence.
  always_comb begin
    nxt_key = key_ff;
    if (err) begin
      nxt_key = fwg_pkg::KEY_LOCKED;
    end else if (core_bad_key) begin
      nxt_key = fwg_pkg::KEY_DEAD;
    end else if (core_blk || (done && own_core_ff)) begin
      nxt_key = fwg_pkg::KEY_LOCKED;
    end else if (key_wr) begin
      case (key_ff)
        fwg_pkg::KEY_LOCKED: begin
          nxt_key = (I_SFR_WDATA == fwg_pkg::KEY_FIRST) ?
                    fwg_pkg::KEY_HALF : fwg_pkg::KEY_DEAD;
        end
        fwg_pkg::KEY_HALF: begin
          nxt_key = (I_SFR_WDATA == fwg_pkg::KEY_SECOND) ?
                    fwg_pkg::KEY_OPEN : fwg_pkg::KEY_DEAD;
        end
        default: begin
          nxt_key = fwg_pkg::KEY_DEAD;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      key_ff <= fwg_pkg::KEY_LOCKED;
    end else begin
      key_ff <= nxt_key;
    end
  end

  // Operation sequencer; the flash macro times each operation.
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      fwg_pkg::ST_IDLE: begin
        if (core_fault) begin
          nxt_st = fwg_pkg::ST_ERR;
        end else if (core_go || dbg_go) begin
          nxt_st = fwg_pkg::ST_BUSY;
        end
      end
      fwg_pkg::ST_BUSY: begin
        if (I_FL_DONE) begin
          nxt_st = fwg_pkg::ST_IDLE;
        end
      end
      fwg_pkg::ST_ERR: begin
        nxt_st = fwg_pkg::ST_IDLE;
      end
      default: begin
        nxt_st = fwg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_ff <= fwg_pkg::ST_IDLE;
      own_core_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (core_go || dbg_go) begin
        own_core_ff <= core_go;
      end
    end
  end

  // Flash macro commands. The cell array only clears bits on a
  // write and fills a page with 0xff on erase.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_FL_RD <= 1'b0;
      O_FL_WR <= 1'b0;
      O_FL_ERASE <= 1'b0;
      O_FL_MASS <= 1'b0;
      O_FL_ADDR <= 16'h0000;
      O_FL_WDATA <= 8'h00;
    end else begin
      O_FL_RD <= dbg_go && (I_DBG_CMD == fwg_pkg::DBG_RD);
      O_FL_WR <= (core_go && !ee_ff) ||
                 (dbg_go && (I_DBG_CMD == fwg_pkg::DBG_WR));
      O_FL_ERASE <= (core_go && ee_ff) ||
                    (dbg_go && (I_DBG_CMD == fwg_pkg::DBG_ER));
      O_FL_MASS <= dbg_go && dbg_mass;
      if (core_go) begin
        O_FL_ADDR <= I_XW_ADDR;
        O_FL_WDATA <= I_XW_DATA;
      end else if (dbg_go) begin
        O_FL_ADDR <= I_DBG_ADDR;
        O_FL_WDATA <= I_DBG_DATA;
      end
    end
  end

  // Core-facing, debug and register read outputs.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_XDATA_RAM_WR <= 1'b0;
      O_CORE_STALL <= 1'b0;
      O_DBG_ACK <= 1'b0;
      O_DBG_DENY <= 1'b0;
      O_FLASH_ERR_RST <= 1'b0;
      O_READ_TIME_SEL <= 1'b0;
      O_SFR_RDATA <= 8'h00;
    end else begin
      // External move reads never reach this block; they stay in ram.
      O_XDATA_RAM_WR <= I_XW_REQ && !we_ff;
      O_CORE_STALL <= nxt_st == fwg_pkg::ST_BUSY;
      O_DBG_ACK <= done && !own_core_ff;
      O_DBG_DENY <= dbg_deny;
      O_FLASH_ERR_RST <= idle && core_fault;
      O_READ_TIME_SEL <= rt_ff;
      case (I_SFR_ADDR)
        fwg_pkg::ADDR_PSC: begin
          O_SFR_RDATA <= {6'h00, ee_ff, we_ff};
        end
        fwg_pkg::ADDR_SCL: begin
          O_SFR_RDATA <= {3'h0, rt_ff, 4'h0};
        end
        fwg_pkg::ADDR_KEY: begin
          O_SFR_RDATA <= {6'h00, key_ff};
        end
        default: begin
          O_SFR_RDATA <= fwg_pkg::RD_ZERO;
        end
      endcase
    end
  end

  AST_KEY_FIRST: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    key_wr && idle && !xw_fl && key_ff == fwg_pkg::KEY_LOCKED &&
    I_SFR_WDATA == fwg_pkg::KEY_FIRST |=> key_ff == fwg_pkg::KEY_HALF)
    else $error("first key code not taken");

  AST_KEY_BAD: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    key_wr && idle && !xw_fl && !cr_fault && key_ff == fwg_pkg::KEY_LOCKED &&
    I_SFR_WDATA != fwg_pkg::KEY_FIRST |=> key_ff == fwg_pkg::KEY_DEAD)
    else $error("wrong key did not disable flash");

  AST_EARLY_OP: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    idle && xw_fl && key_ff != fwg_pkg::KEY_OPEN
    |=> key_ff == fwg_pkg::KEY_DEAD && !O_FL_WR && !O_FL_ERASE)
    else $error("operation while locked did not disable flash");

  AST_ERASE_EN: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    O_FL_ERASE && own_core_ff |-> $past(ee_ff) && $past(we_ff))
    else $error("erase without both enables");

  AST_RELOCK: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    done && own_core_ff
    |=> key_ff == fwg_pkg::KEY_LOCKED)
    else $error("key not relocked after operation");

  AST_LPG_ERASE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    core_try && ee_ff && xw_lp |=> O_FLASH_ERR_RST && !O_FL_ERASE)
    else $error("lock page erase did not reset");

  AST_ERR_CLEAR: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    O_FLASH_ERR_RST |=> !we_ff && !ee_ff && key_ff == fwg_pkg::KEY_LOCKED)
    else $error("flash error left controls set");

  AST_DBG_LOCKED: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    dbg_take && dbg_lk && !dbg_mass |=> O_DBG_DENY ##1 st_ff == fwg_pkg::ST_IDLE)
    else $error("debug access to locked page not refused");

  AST_RSV: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    O_FL_RD || O_FL_WR || O_FL_ERASE |-> O_FL_ADDR < fwg_pkg::RSV_BASE)
    else $error("reserved area accessed");

  AST_STALL: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    core_go |=> O_CORE_STALL && st_ff == fwg_pkg::ST_BUSY)
    else $error("core not stalled during flash operation");
endmodule
`default_nettype wire

// ==== fwg_pkg.sv ====
// Constants and types for the flash write guard and security block.
// Assumes a byte-wide special register bus and a 16-bit code space.
package fwg_pkg;
  // Special register addresses.
  localparam logic [7:0] ADDR_PSC = 8'h8f;
  localparam logic [7:0] ADDR_SCL = 8'hb6;
  localparam logic [7:0] ADDR_KEY = 8'hb7;
  // Field positions and reset values.
  localparam int WE_BIT = 0;
  localparam int EE_BIT = 1;
  localparam int RT_BIT = 4;
  localparam logic RST_BIT = 1'b0;
  localparam logic [7:0] RD_ZERO = 8'h00;
  // Key codes.
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  // Flash map, 512-byte pages.
  localparam int PG_LSB = 9;
  localparam logic [15:0] LPG_BASE = 16'h1c00;
  localparam logic [15:0] LPG_LAST = 16'h1dff;
  localparam logic [15:0] LOCK_BYTE_ADDR = 16'h1dff;
  localparam logic [15:0] RSV_BASE = 16'h1e00;
  localparam logic [15:0] RSV_LAST = 16'h1fff;
  // Debug port commands.
  localparam logic [1:0] DBG_RD = 2'h0;
  localparam logic [1:0] DBG_WR = 2'h1;
  localparam logic [1:0] DBG_ER = 2'h2;
  localparam logic [1:0] DBG_DEV_ER = 2'h3;
  // Key state as read back from the key register.
  typedef enum logic [1:0] {
    KEY_LOCKED = 2'h0,
    KEY_HALF = 2'h1,
    KEY_OPEN = 2'h2,
    KEY_DEAD = 2'h3
  } fwg_key_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BUSY = 3'h2,
    ST_ERR = 3'h4
  } fwg_st_t;
endpackage

// ==== fwg_page_check.sv ====
// Classifies one flash address against the security lock byte.
// Assumes the lock byte value is stable while it is read.
`timescale 1ns/1ps
`default_nettype none
module fwg_page_check (
  input wire logic [15:0] i_addr, // Address under test
  input wire logic [7:0] i_lock_byte, // Current lock byte
  output logic o_locked, // Address is in a locked page
  output logic o_lock_page, // Address is in the lock-byte page
  output logic o_reserved, // Address is in the reserved area
  output logic o_any_locked // At least one page is locked
);
  logic [7:0] n_pages;
  logic [7:0] page;

  always_comb begin
    n_pages = ~i_lock_byte;
    page = {1'b0, i_addr[15:fwg_pkg::PG_LSB]};
    o_any_locked = n_pages != 8'h00;
    o_reserved = i_addr >= fwg_pkg::RSV_BASE;
    o_lock_page = (i_addr >= fwg_pkg::LPG_BASE) &&
                  (i_addr <= fwg_pkg::LPG_LAST);
    // The lock-byte page follows any other lock.
    o_locked = !o_reserved && ((page < n_pages) ||
               (o_lock_page && o_any_locked));
  end
endmodule
`default_nettype wire

// ==== fwg_flash_model.sv ====
// Flash array model: lock byte storage and op timing.
// Assumes start pulses from fwg_top on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fwg_flash_model (
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_start, // Any op start
  input wire logic i_wr, // Byte write start
  input wire logic i_erase, // Page erase start
  input wire logic i_mass, // Full erase start
  input wire logic [15:0] i_addr, // Op address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic [3:0] i_delay, // Cycles to completion, less one
  output logic o_done, // Op complete pulse
  output logic [7:0] o_lock_byte // Lock byte contents
);
  logic [3:0] cnt_ff;
  logic busy_ff;
  initial o_lock_byte = 8'hff;
  // Writes only clear bits; a lock page erase or full erase fills ones.
  always @(posedge i_clk) begin
    if (i_wr && i_addr == 16'h1dff) begin
      o_lock_byte <= o_lock_byte & i_wdata;
    end
    if (i_mass || (i_erase && i_addr[15:9] == 7'h0e)) begin
      o_lock_byte <= 8'hff;
    end
  end
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= busy_ff && cnt_ff == 4'h0;
      if (i_start) begin
        busy_ff <= 1'b1;
        cnt_ff <= i_delay;
      end else if (busy_ff && cnt_ff == 4'h0) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== flash_write_guard_and_security_test.sv ====
// Self-checking bench for fwg_top with a flash model.
// Assumes the flash model answers every start pulse.
`timescale 1ns/1ps
`default_nettype none
module flash_write_guard_and_security_test;
  logic clk, rst_n, sfr_wr, xw_req, cr_req, dbg_req, fl_done, xdata_ram_wr, stall;
  logic dbg_ack, dbg_deny, fl_rd, fl_wr, fl_erase, fl_mass, rt_sel, err_rst;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xw_data, dbg_data, lock_byte, fl_wdata;
  logic [15:0] xw_addr, cr_addr, pc_addr, dbg_addr, fl_addr;
  logic [1:0] dbg_cmd;
  logic [3:0] dly;
  logic [7:0] lf, ev;
  logic [7:0] expq[$];
  int n_mismatch, n_tests, i;
  localparam logic [7:0] EX = 8'h01, EW = 8'h02, EE = 8'h04, EM = 8'h08;
  localparam logic [7:0] ER = 8'h10, EF = 8'h20, ED = 8'h40, EA = 8'h80;
  localparam logic [7:0] PSC = fwg_pkg::ADDR_PSC, KEY = fwg_pkg::ADDR_KEY;
  fwg_top u_dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_SFR_ADDR(sfr_addr),
    .I_SFR_WR(sfr_wr), .I_SFR_WDATA(sfr_wdata), .O_SFR_RDATA(sfr_rdata),
    .I_XW_REQ(xw_req), .I_XW_ADDR(xw_addr), .I_XW_DATA(xw_data), .O_XDATA_RAM_WR(xdata_ram_wr),
    .O_CORE_STALL(stall), .I_CR_REQ(cr_req), .I_CR_ADDR(cr_addr), .I_PC_ADDR(pc_addr),
    .I_DBG_REQ(dbg_req), .I_DBG_CMD(dbg_cmd), .I_DBG_ADDR(dbg_addr),
    .I_DBG_DATA(dbg_data), .O_DBG_ACK(dbg_ack), .O_DBG_DENY(dbg_deny),
    .I_LOCK_BYTE(lock_byte), .O_FL_RD(fl_rd), .O_FL_WR(fl_wr), .O_FL_ERASE(fl_erase),
    .O_FL_MASS(fl_mass), .O_FL_ADDR(fl_addr), .O_FL_WDATA(fl_wdata),
    .I_FL_DONE(fl_done), .O_READ_TIME_SEL(rt_sel), .O_FLASH_ERR_RST(err_rst));
  fwg_flash_model u_flash (.i_clk(clk), .i_rst_n(rst_n),
    .i_start(fl_rd | fl_wr | fl_erase | fl_mass), .i_wr(fl_wr), .i_erase(fl_erase),
    .i_mass(fl_mass), .i_addr(fl_addr), .i_wdata(fl_wdata), .i_delay(dly),
    .o_done(fl_done), .o_lock_byte(lock_byte));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // Each output event is matched against the oldest noted expectation.
  assign ev = {dbg_ack, dbg_deny, err_rst, fl_rd, fl_mass, fl_erase, fl_wr, xdata_ram_wr};
  always @(negedge clk) begin
    if (ev !== 8'h00) begin
      if (expq.size() == 0) check(1'b0, "event with none expected");
      else check(ev === expq.pop_front(), "wrong event");
    end
  end
  task automatic rst();
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic sfr_r(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    @(negedge clk);
    check(sfr_rdata === e, "register read");
  endtask
  task automatic unlock();
    sfr_w(KEY, fwg_pkg::KEY_FIRST);
    sfr_w(KEY, fwg_pkg::KEY_SECOND);
  endtask
  // Kind 0 to 3 is a debug command, 4 a core write, 5 a code read.
  task automatic op(input int k, input logic [15:0] a, input logic [7:0] d,
      input logic [7:0] e1, input logic [7:0] e2);
    if (e1 != 8'h00) expq.push_back(e1);
    if (e2 != 8'h00) expq.push_back(e2);
    @(negedge clk);
    xw_addr = a;
    cr_addr = a;
    dbg_addr = a;
    xw_data = d;
    dbg_data = d;
    dbg_cmd = k[1:0];
    xw_req = (k == 4);
    cr_req = (k == 5);
    dbg_req = (k < 4);
    @(negedge clk);
    {xw_req, cr_req, dbg_req} = 3'b000;
    if (k == 4 && e1 == EW) check(stall === 1'b1 && fl_wdata === d, "write start");
    for (i = 0; i < 200 && (expq.size() != 0 || stall !== 1'b0); i++) @(negedge clk);
    check(expq.size() == 0, "expected event missing");
    repeat (2) @(negedge clk);
  endtask
  initial begin
    {rst_n, sfr_wr, xw_req, cr_req, dbg_req, sfr_addr, sfr_wdata, xw_data} = '0;
    {dbg_data, xw_addr, cr_addr, dbg_addr, dbg_cmd, n_mismatch, n_tests} = '0;
    pc_addr = 16'h0400;
    dly = 4'h3;
    lf = 8'h4f;
    rst();
    sfr_r(PSC, 8'h00);
    sfr_r(fwg_pkg::ADDR_SCL, 8'h00);
    sfr_r(KEY, 8'h00);
    sfr_r(8'h00, 8'h00);
    sfr_w(PSC, 8'hff);
    sfr_r(PSC, 8'h03);
    sfr_w(fwg_pkg::ADDR_SCL, 8'hff);
    sfr_r(fwg_pkg::ADDR_SCL, 8'h10);
    check(rt_sel === 1'b1, "read time bit");
    $display("done: registers");
    sfr_w(PSC, 8'h00);
    op(4, 16'h0100, 8'h5a, EX, 8'h00);
    sfr_w(PSC, 8'h01);
    sfr_w(KEY, fwg_pkg::KEY_FIRST);
    sfr_r(KEY, 8'h01);
    sfr_w(KEY, fwg_pkg::KEY_SECOND);
    sfr_r(KEY, 8'h02);
    for (int n = 0; n < 4; n++) begin
      lf = lfsr(lf);
      dly = lf[3:0];
      if (n > 0) unlock();
      op(4, {8'h04, lf}, lf, EW, 8'h00);
      check(fl_addr === {8'h04, lf}, "write address");
      sfr_r(KEY, 8'h00);
    end
    sfr_w(PSC, 8'h02);
    op(4, 16'h0600, 8'h00, EX, 8'h00);
    sfr_w(PSC, 8'h03);
    unlock();
    op(4, 16'h0600, 8'h00, EE, 8'h00);
    op(4, 16'h0800, 8'h00, 8'h00, 8'h00);
    unlock();
    sfr_r(KEY, 8'h03);
    rst();
    sfr_w(KEY, 8'h12);
    sfr_r(KEY, 8'h03);
    rst();
    $display("done: key and enables");
    sfr_w(PSC, 8'h01);
    unlock();
    op(4, fwg_pkg::LOCK_BYTE_ADDR, 8'hfe, EW, 8'h00);
    check(lock_byte === 8'hfe, "lock byte written");
    op(0, 16'h01ff, 8'h00, ED, 8'h00);
    op(0, 16'h0200, 8'h00, ER, EA);
    op(0, 16'h1dff, 8'h00, ED, 8'h00);
    op(1, 16'h1c00, 8'h00, ED, 8'h00);
    unlock();
    op(4, 16'h1dff, 8'h00, EF, 8'h00);
    sfr_r(KEY, 8'h00);
    op(5, 16'h0010, 8'h00, EF, 8'h00);
    op(5, 16'h1e00, 8'h00, EF, 8'h00);
    sfr_w(PSC, 8'h01);
    unlock();
    op(4, 16'h1c10, 8'h00, EF, 8'h00);
    sfr_r(PSC, 8'h00);
    $display("done: unlocked code");
    pc_addr = 16'h0000;
    sfr_w(PSC, 8'h03);
    unlock();
    op(4, 16'h1c00, 8'h00, EF, 8'h00);
    sfr_r(KEY, 8'h00);
    sfr_w(PSC, 8'h01);
    unlock();
    op(4, 16'h0020, 8'h3c, EW, 8'h00);
    unlock();
    op(4, 16'h1c20, 8'h77, EW, 8'h00);
    unlock();
    op(4, 16'h1dff, 8'h00, 8'h00, 8'h00);
    sfr_r(KEY, 8'h00);
    check(lock_byte === 8'hfe, "lock byte kept");
    unlock();
    op(4, 16'h1fff, 8'h00, EF, 8'h00);
    $display("done: locked code");
    op(3, 16'h0000, 8'h00, EM, EA);
    check(lock_byte === 8'hff, "locks cleared");
    op(0, 16'h0000, 8'h00, ER, EA);
    op(0, 16'h1dff, 8'h00, ER, EA);
    $display("done: debug erase");
    print_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
